// ### core/gp_timers.sv
// Nine general purpose timers: one standalone 16-bit timer and four pairs
// that run as two 16-bit timers or one cascaded 32-bit timer, behind APB.
// Assumes pins, gate inputs and the idle indication are synchronous to core_clk_i.
//
// Functional notes
// - Standalone timer is a 16-bit timer, sync counter or async counter.
// - Standalone timer flags on period match or gated-mode gate falling edge.
// - timer_run set starts counting, cleared stops the timer.
// - idle_stop set halts the timer in Idle; cleared keeps it running.
// - gate_accumulate_en gates counting on internal clock, ignored on external.
// - prescale_select 11/10/01/00 divides by 256/64/8/1.
// - ext_clock_sync chooses synchronised external clock; ignored for internal clock.
// - clock_source_select 1 counts external rising edges, 0 the instruction clock.
// - Unimplemented control bits, including 12 to 7, read as zero.
// - Each paired timer alone supports all synchronous 16-bit modes.
// - Cascaded pair is one 32-bit timer or counter matching a 32-bit period.
// - pair_32bit_mode joins even and odd timers into one 32-bit timer.
// - Even timer is the low count word, odd timer the high word.
// - In cascade the odd control bits are ignored; even controls everything.
// - Cascaded match is flagged on the odd timer's flag only.
// - Odd period register holds upper period word, even the lower word.
// - In cascade the odd count register holds the upper count word.
// - Pair 2/3 makes the first ADC trigger, pair 4/5 the second.
// - Only timers 2 and 3 provide capture and compare time bases.
// - Only timers 2 and 3 may request DMA transfers.
// - Standalone timer keeps running in Idle and Sleep when allowed.
// - Bit 3 of even control selects cascaded 32-bit mode.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`default_nettype none
module gp_timers (
  input  wire logic                                   core_clk_i,
  input  wire logic                                   arst_n_i,
  input  wire gp_timers_pkg::apb_req_type             apb_i,
  output gp_timers_pkg::apb_rsp_type                  apb_o,
  input  wire logic [gp_timers_pkg::NUM_TIMERS-1:0]   ext_clock_i,
  input  wire logic [gp_timers_pkg::NUM_TIMERS-1:0]   gate_i,
  input  wire logic                                   idle_mode_i,
  output logic      [gp_timers_pkg::NUM_TIMERS-1:0]   irq_flag_o,
  output logic      [1:0]                             adc_trigger_o,
  output logic      [1:0]                             dma_request_o,
  output logic      [15:0]                            timebase2_o,
  output logic      [15:0]                            timebase3_o
);
  import gp_timers_pkg::*;

  typedef struct packed {
    logic [NUM_TIMERS-1:0][15:0] ctrl;
    logic [NUM_TIMERS-1:0][15:0] period;
    logic [NUM_TIMERS-1:0][15:0] count;
    logic [NUM_TIMERS-1:0][7:0]  pre;
    logic [NUM_TIMERS-1:0]       flag;
    logic [NUM_TIMERS-1:0]       gate_prev;
    logic [NUM_TIMERS-1:0]       sync1;
    logic [NUM_TIMERS-1:0]       sync2;
    logic [NUM_TIMERS-1:0]       sync3;
    logic                        raw_prev;
    logic [1:0]                  adc_trig;
    logic [1:0]                  dma_req;
    logic [31:0]                 prdata;
    logic                        pslverr;
  } state_type;

  state_type state_q;
  state_type state_d;

  function automatic logic [7:0] prescale_term(input logic [1:0] sel);
    case (sel)
      2'b11:   prescale_term = PS_TERM_256;
      2'b10:   prescale_term = PS_TERM_64;
      2'b01:   prescale_term = PS_TERM_8;
      default: prescale_term = PS_TERM_1;
    endcase
  endfunction

  function automatic logic [15:0] ctrl_mask(input int unsigned idx);
    if (idx == 0) begin
      ctrl_mask = MASK_STANDALONE;
    end else if (idx % 2 == 1) begin
      ctrl_mask = MASK_EVEN;
    end else begin
      ctrl_mask = MASK_ODD;
    end
  endfunction

  // Checks that a byte address is the flag register or a timer's control, period or count slot.
  function automatic logic addr_valid(input logic [ADDR_W-1:0] addr);
    logic [3:0] tsel;
    logic [3:0] rsel;
    tsel = addr[7:4];
    rsel = addr[3:0];
    if (addr == ADDR_FLAGS) begin
      addr_valid = 1'b1;
    end else if (tsel < 4'(NUM_TIMERS) && (rsel == OFF_CTRL || rsel == OFF_PERIOD ||
                 rsel == OFF_COUNT)) begin
      addr_valid = 1'b1;
    end else begin
      addr_valid = 1'b0;
    end
  endfunction

  always_comb begin
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] active;
    logic [NUM_TIMERS-1:0] match;
    logic [NUM_TIMERS-1:0] set_flag;
    logic [NUM_TIMERS-1:0] clr_flag;
    logic [NUM_TIMERS-1:0] cascade_odd;
    logic [15:0]           ctl;
    logic                  edge_seen;
    logic                  in_tick;
    logic                  gated;
    logic [31:0]           c32;
    logic [31:0]           p32;
    logic                  setup;
    logic                  wr;
    logic [3:0]            tsel;
    logic [3:0]            rsel;
    tick        = '0;
    active      = '0;
    match       = '0;
    set_flag    = '0;
    clr_flag    = '0;
    cascade_odd = '0;
    ctl         = '0;
    edge_seen   = 1'b0;
    in_tick     = 1'b0;
    gated       = 1'b0;
    c32         = '0;
    p32         = '0;
    state_d     = state_q;

    // External clock synchroniser and edge history.
    state_d.sync1     = ext_clock_i;
    state_d.sync2     = state_q.sync1;
    state_d.sync3     = state_q.sync2;
    state_d.raw_prev  = ext_clock_i[0];
    state_d.gate_prev = gate_i;

    for (int unsigned p = 0; p < NUM_PAIRS; p++) begin
      cascade_odd[2 + 2 * p] = state_q.ctrl[1 + 2 * p][BIT_PAIR32];
    end

    // Input clock selection, gating and prescaler for each timer.
    for (int unsigned i = 0; i < NUM_TIMERS; i++) begin
      ctl = state_q.ctrl[i];
      if (i == 0 && !ctl[BIT_SYNC]) begin
        edge_seen = ext_clock_i[0] & ~state_q.raw_prev;
      end else begin
        edge_seen = state_q.sync2[i] & ~state_q.sync3[i];
      end
      gated = !ctl[BIT_CLK_SEL] && ctl[BIT_GATE];
      if (ctl[BIT_CLK_SEL]) begin
        in_tick = edge_seen;
      end else if (gated) begin
        in_tick = gate_i[i];
      end else begin
        in_tick = 1'b1;
      end
      active[i] = ctl[BIT_RUN] && !(ctl[BIT_IDLE_STOP] && idle_mode_i)
                  && !cascade_odd[i];
      if (active[i] && in_tick) begin
        if (state_q.pre[i] >= prescale_term(ctl[BIT_PS_HI:BIT_PS_LO])) begin
          state_d.pre[i] = '0;
          tick[i]        = 1'b1;
        end else begin
          state_d.pre[i] = state_q.pre[i] + 8'h01;
        end
      end
      if (active[i] && gated && state_q.gate_prev[i] && !gate_i[i]) begin
        set_flag[i] = 1'b1;
      end
    end

    // Counting: 16-bit per timer, or 32-bit on the even timer of a cascaded pair.
    for (int unsigned i = 0; i < NUM_TIMERS; i++) begin
      if (i != 0 && i % 2 == 1 && state_q.ctrl[i][BIT_PAIR32]) begin
        c32 = {state_q.count[i + 1], state_q.count[i]};
        p32 = {state_q.period[i + 1], state_q.period[i]};
        if (tick[i]) begin
          if (c32 == p32) begin
            state_d.count[i]     = '0;
            state_d.count[i + 1] = '0;
            match[i + 1]         = 1'b1;
          end else begin
            c32                  = c32 + 32'h0000_0001;
            state_d.count[i]     = c32[15:0];
            state_d.count[i + 1] = c32[31:16];
          end
        end
      end else if (!cascade_odd[i] && tick[i]) begin
        if (state_q.count[i] == state_q.period[i]) begin
          state_d.count[i] = '0;
          match[i]         = 1'b1;
        end else begin
          state_d.count[i] = state_q.count[i] + 16'h0001;
        end
      end
    end
    set_flag = set_flag | match;

    // Pair events: ADC triggers for pairs 2/3 and 4/5, DMA for timers 2 and 3 only.
    state_d.adc_trig[0] = match[1] | match[2];
    state_d.adc_trig[1] = match[3] | match[4];
    state_d.dma_req     = {match[2], match[1]};

    // APB slave: decode in the setup cycle, complete with no wait state.
    setup = apb_i.psel && !apb_i.penable;
    wr    = apb_i.psel && apb_i.penable && apb_i.pwrite && addr_valid(apb_i.paddr);
    tsel  = apb_i.paddr[7:4];
    rsel  = apb_i.paddr[3:0];
    if (setup) begin
      state_d.pslverr = !addr_valid(apb_i.paddr);
      state_d.prdata  = '0;
      if (apb_i.paddr == ADDR_FLAGS) begin
        state_d.prdata[NUM_TIMERS-1:0] = state_q.flag;
      end else if (addr_valid(apb_i.paddr)) begin
        for (int unsigned i = 0; i < NUM_TIMERS; i++) begin
          if (tsel == 4'(i)) begin
            case (rsel)
              OFF_CTRL:   state_d.prdata[15:0] = state_q.ctrl[i] & ctrl_mask(i);
              OFF_PERIOD: state_d.prdata[15:0] = state_q.period[i];
              OFF_COUNT:  state_d.prdata[15:0] = state_q.count[i];
              default:    state_d.prdata[15:0] = '0;
            endcase
          end
        end
      end
    end
    if (wr) begin
      if (apb_i.paddr == ADDR_FLAGS) begin
        clr_flag = apb_i.pwdata[NUM_TIMERS-1:0];
      end else begin
        for (int unsigned i = 0; i < NUM_TIMERS; i++) begin
          if (tsel == 4'(i)) begin
            case (rsel)
              OFF_CTRL: begin
                state_d.ctrl[i] = apb_i.pwdata[15:0] & ctrl_mask(i);
                state_d.pre[i]  = '0;
              end
              OFF_PERIOD: state_d.period[i] = apb_i.pwdata[15:0];
              OFF_COUNT:  state_d.count[i]  = apb_i.pwdata[15:0];
              default:    state_d.count[i]  = state_d.count[i];
            endcase
          end
        end
      end
    end
    // A match in the clearing cycle keeps its flag set.
    state_d.flag = (state_q.flag & ~clr_flag) | set_flag;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q           <= '0;
      state_q.ctrl      <= {NUM_TIMERS{CTRL_RESET}};
      state_q.period    <= {NUM_TIMERS{PERIOD_RESET}};
      state_q.count     <= {NUM_TIMERS{COUNT_RESET}};
    end else begin
      state_q <= state_d;
    end
  end

  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = state_q.pslverr;
  assign apb_o.prdata  = state_q.prdata;
  assign irq_flag_o    = state_q.flag;
  assign adc_trigger_o = state_q.adc_trig;
  assign dma_request_o = state_q.dma_req;
  assign timebase2_o   = state_q.count[1];
  assign timebase3_o   = state_q.count[2];

endmodule
`default_nettype wire

// ### core/gp_timers_pkg.sv
// Package for the general purpose timer set: register map, field positions,
// reset values and the carrier types shared by the design and the bench.
// Assumes a single 40 MHz core clock that also serves as the instruction clock.
`default_nettype none
package gp_timers_pkg;

  localparam int unsigned NUM_TIMERS = 9;
  localparam int unsigned NUM_PAIRS  = 4;
  localparam int unsigned ADDR_W     = 8;

  // Byte offsets: timer n (0 = standalone, 1..8 = paired) sits at n * TIMER_STRIDE.
  localparam logic [7:0] TIMER_STRIDE = 8'h10;
  localparam logic [3:0] OFF_CTRL     = 4'h0;
  localparam logic [3:0] OFF_PERIOD   = 4'h4;
  localparam logic [3:0] OFF_COUNT    = 4'h8;
  localparam logic [3:0] OFF_FLAGS    = 4'hC;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0C;

  // Control register field positions.
  localparam int unsigned BIT_RUN       = 15;
  localparam int unsigned BIT_IDLE_STOP = 13;
  localparam int unsigned BIT_GATE      = 6;
  localparam int unsigned BIT_PS_HI     = 5;
  localparam int unsigned BIT_PS_LO     = 4;
  localparam int unsigned BIT_PAIR32    = 3;
  localparam int unsigned BIT_SYNC      = 2;
  localparam int unsigned BIT_CLK_SEL   = 1;

  // Writable bits per control register flavour; the rest read as zero.
  localparam logic [15:0] MASK_STANDALONE = 16'hA076;
  localparam logic [15:0] MASK_EVEN       = 16'hA07A;
  localparam logic [15:0] MASK_ODD        = 16'hA072;

  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;

  // Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256.
  localparam logic [7:0] PS_TERM_1   = 8'h00;
  localparam logic [7:0] PS_TERM_8   = 8'h07;
  localparam logic [7:0] PS_TERM_64  = 8'h3F;
  localparam logic [7:0] PS_TERM_256 = 8'hFF;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
  } apb_req_type;

  typedef struct packed {
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } apb_rsp_type;

endpackage
`default_nettype wire

// ### bench/gp_timers_properties.sv
// Property checker for the timer set: APB answers and timer output relations.
// Assumes it is bound to gp_timers, so every input is one of its ports.
`default_nettype none
module gp_timers_properties (
  input wire logic                       core_clk_i,
  input wire logic                       arst_n_i,
  input wire gp_timers_pkg::apb_req_type apb_i,
  input wire gp_timers_pkg::apb_rsp_type apb_o,
  input wire logic [8:0]                 irq_flag_o,
  input wire logic [1:0]                 adc_trigger_o,
  input wire logic [1:0]                 dma_request_o,
  input wire logic [15:0]                timebase2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gp_timers_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic bad = !(apb_i.paddr == ADDR_FLAGS || (apb_i.paddr[7:4] < 4'h9
                   && (apb_i.paddr[3:0] == OFF_CTRL || apb_i.paddr[3:0] == OFF_PERIOD
                   || apb_i.paddr[3:0] == OFF_COUNT)));
  wire logic wr  = apb_i.psel && apb_i.penable && apb_i.pwrite;
  sequence s_setup;
    apb_i.psel && !apb_i.penable;
  endsequence
  property p_ready;
    apb_o.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    s_setup |=> apb_o.pslverr == $past(bad) && ($past(!bad) || apb_o.prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("bad slave error answer");
  property p_ctrl;
    s_setup ##0 (apb_i.paddr[3:0] == 4'h0 && !bad) |=> apb_o.prdata[31:16] == 16'h0
      && (apb_o.prdata[15:0] & ~(MASK_EVEN | MASK_STANDALONE)) == 16'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("unused control bits read set");
  property p_clr;
    ($past(irq_flag_o) & ~irq_flag_o) != 9'h0 |-> $past(wr && apb_i.paddr == ADDR_FLAGS)
      && ($past(irq_flag_o) & ~irq_flag_o & ~$past(apb_i.pwdata[8:0])) == 9'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("flag fell without a clear");
  property p_step;
    $changed(timebase2_o) |-> timebase2_o == $past(timebase2_o) + 16'h1 || timebase2_o == 16'h0
      || $past(wr && apb_i.paddr == 8'h18) || $past(wr && apb_i.paddr == 8'h18, 2);
  endproperty
  a_step: assert property (p_step) else $error("time base jumped");
  property p_dma;
    dma_request_o[1] |-> irq_flag_o[2];
  endproperty
  a_dma: assert property (p_dma) else $error("dma without match");
  property p_adc0;
    adc_trigger_o[0] |-> irq_flag_o[1] || irq_flag_o[2];
  endproperty
  a_adc0: assert property (p_adc0) else $error("first trigger without match");
  property p_adc1;
    adc_trigger_o[1] |-> irq_flag_o[3] || irq_flag_o[4];
  endproperty
  a_adc1: assert property (p_adc1) else $error("second trigger without match");
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the timer set: APB tasks and register scenarios.
// Assumes the package, gp_timers and the property checker are compiled first.
`default_nettype none
bind gp_timers gp_timers_properties chk_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .apb_i(apb_i), .apb_o(apb_o), .irq_flag_o(irq_flag_o), .adc_trigger_o(adc_trigger_o),
  .dma_request_o(dma_request_o), .timebase2_o(timebase2_o));
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gp_timers_pkg::*;
  logic        clk, rst_n, idle, err;
  apb_req_type req;
  apb_rsp_type rsp;
  logic [8:0]  ext, gate, irq;
  logic [1:0]  adc, dma, adc_seen, dma_seen;
  logic [15:0] tb2, tb3, held;
  logic [31:0] q;
  int          n_errors, checks_done;
  int          divs[4] = '{1, 8, 64, 256};
  gp_timers DUT (.core_clk_i(clk), .arst_n_i(rst_n), .apb_i(req), .apb_o(rsp),
    .ext_clock_i(ext), .gate_i(gate), .idle_mode_i(idle), .irq_flag_o(irq),
    .adc_trigger_o(adc), .dma_request_o(dma), .timebase2_o(tb2), .timebase3_o(tb3));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (!rst_n) begin
      adc_seen <= '0;
      dma_seen <= '0;
    end else begin
      adc_seen <= adc_seen | adc;
      dma_seen <= dma_seen | dma;
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    req <= '{1'b1, 1'b0, w, a, {16'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wflag(input int b);
    repeat (40) if (irq[b] !== 1'b1) @(posedge clk);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    clk = 1'b0; rst_n = 1'b0; idle = 1'b0; req = '0; ext = '0; gate = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, 8'h04, 0); chk("period reset", q, 32'h0000FFFF);
    bus(0, 8'h00, 0); chk("ctrl reset", q, 32'h0);
    bus(1, 8'h00, 16'hFFFF); bus(0, 8'h00, 0); chk("ctrl mask", q, {16'h0, MASK_STANDALONE});
    bus(1, 8'h10, 16'hFFFF); bus(0, 8'h10, 0); chk("even mask", q, {16'h0, MASK_EVEN});
    bus(1, 8'h20, 16'hFFFF); bus(0, 8'h20, 0); chk("odd mask", q, {16'h0, MASK_ODD});
    bus(1, 8'h00, 0); bus(1, 8'h10, 0); bus(1, 8'h20, 0); bus(1, 8'h9C, 16'h1234);
    bus(0, 8'h9C, 0); chk("unmapped", {err, q[30:0]}, 32'h80000000);
    bus(1, 8'h04, 16'h0002); bus(1, 8'h0C, 16'h01FF); bus(1, 8'h08, 0); bus(1, 8'h00, 16'h8000);
    wflag(0); chk("match flag", irq[0], 1'b1);
    bus(0, 8'h08, 0); chk("wrap", q <= 32'h2, 1'b1);
    bus(1, 8'h00, 0); bus(1, 8'h0C, 16'h01FF); bus(0, 8'h08, 0); held = q[15:0];
    bus(0, 8'h0C, 0); chk("flag clear", q, 32'h0);
    bus(0, 8'h08, 0); chk("stopped", q[15:0], held);
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h04, 16'hFFFF); bus(1, 8'h08, 0); bus(1, 8'h00, 16'h8000 | (16'(i) << 4));
      repeat (4 * divs[i] - 3) @(posedge clk);
      bus(1, 8'h00, 0); bus(0, 8'h08, 0); chk("prescale", q >= 3 && q <= 5, 1'b1);
    end
    bus(1, 8'h08, 0); idle <= 1'b1; bus(1, 8'h00, 16'hA000); repeat (20) @(posedge clk);
    bus(0, 8'h08, 0); chk("idle halt", q, 32'h0);
    bus(1, 8'h00, 16'h8000); repeat (10) @(posedge clk);
    bus(0, 8'h08, 0); chk("idle run", q != 0, 1'b1);
    idle <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      bus(1, 8'h00, 0); bus(1, 8'h08, 0); bus(1, 8'h00, 16'h8042 | (16'(s) << 2));
      repeat (5) begin
        ext[0] <= 1'b1; repeat (4) @(posedge clk);
        ext[0] <= 1'b0; repeat (4) @(posedge clk);
      end
      bus(0, 8'h08, 0); chk("ext edges", q, 32'h5);
    end
    bus(1, 8'h00, 0); bus(1, 8'h08, 0); bus(1, 8'h0C, 16'h01FF); bus(1, 8'h00, 16'h8040);
    repeat (10) @(posedge clk);
    bus(0, 8'h08, 0); chk("gate low", q, 32'h0);
    gate[0] <= 1'b1; repeat (10) @(posedge clk);
    gate[0] <= 1'b0; repeat (3) @(posedge clk);
    bus(0, 8'h0C, 0); chk("gate fall", q[0], 1'b1);
    chk("no dma", {adc_seen, dma_seen}, 4'h0);
    bus(1, 8'h00, 0); bus(1, 8'h0C, 16'h01FF); bus(1, 8'h14, 16'h0001); bus(1, 8'h24, 16'h0001);
    bus(1, 8'h18, 16'hFFFE); bus(1, 8'h28, 0); idle <= 1'b1; bus(1, 8'h20, 16'hA000);
    bus(1, 8'h10, 16'h8008); wflag(2);
    chk("odd flag", irq[2:1], 2'b10);
    bus(1, 8'h10, 0); chk("first trigger", adc_seen, 2'b01);
    chk("dma request", dma_seen, 2'b10);
    bus(0, 8'h28, 0); chk("upper word", q, 32'h0);
    chk("time base 3", {16'h0, tb3}, q);
    bus(0, 8'h18, 0); chk("time base", {16'h0, tb2}, q);
    idle <= 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
